// ### rtl/gpe_pkg.sv
// Purpose: Constants for the general purpose event block
// Assumes: One 100 MHz clock, 8-bit system I/O window of eight bytes
// Notes:   Offsets are relative to the block's I/O base
//
// Summary of operation
// [RQ1] Peripheral request sets its source status bit
// [RQ2] Status bits: serial B, serial A, floppy, printer
// [RQ3] Writing one clears status; zero leaves it
// [RQ4] Set status bit ignores further requests
// [RQ5] SCI is OR of status AND enable
// [RQ6] Enable bits share the status bit layout
// [RQ7] Second status/enable registers read as zero
// [RQ8] Global release sets firmware event status
// [RQ9] Firmware enable plus release raises SMI event
// [RQ10] Clearing firmware status also clears global release
// [RQ11] Timer run bit starts and halts timer
// [RQ12] All registers hold zero after reset
// [RQ13] 24-bit timer at 3.579545 MHz, keeps value
// [RQ14] Rising edge requests; set beats clearing write
package gpe_pkg;

   ////////////////////////////////////////////////////////////////////////////
   localparam logic [2:0] EVENT0_STATUS_OFS    = 3'h0;
   localparam logic [2:0] EVENT0_STATUS_HI_OFS = 3'h1;
   localparam logic [2:0] EVENT0_ENABLE_OFS    = 3'h2;
   localparam logic [2:0] EVENT0_ENABLE_HI_OFS = 3'h3;
   localparam logic [2:0] EVENT1_STATUS_OFS    = 3'h4;
   localparam logic [2:0] EVENT1_STATUS_HI_OFS = 3'h5;
   localparam logic [2:0] EVENT1_ENABLE_OFS    = 3'h6;

   ////////////////////////////////////////////////////////////////////////////
   localparam int SOURCE_COUNT = 4;
   localparam int SERIAL_B_BIT = 0;
   localparam int SERIAL_A_BIT = 1;
   localparam int FLOPPY_BIT   = 2;
   localparam int PRINTER_BIT  = 3;
   localparam int FIRMWARE_STATUS_BIT = 0;
   localparam int FIRMWARE_ENABLE_BIT = 0;
   localparam int TIMER_RUN_BIT       = 1;

   localparam logic [7:0] REG_RESET = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   localparam int TIMER_WIDTH = 24;
   localparam int unsigned CLOCK_HZ    = 100000000;
   localparam int unsigned PM_TIMER_HZ = 3579545;
   localparam int PHASE_WIDTH = 28;
   localparam logic [PHASE_WIDTH-1:0] PHASE_STEP   = PHASE_WIDTH'(PM_TIMER_HZ);
   localparam logic [PHASE_WIDTH-1:0] PHASE_MODULO = PHASE_WIDTH'(CLOCK_HZ);

endpackage

// ### rtl/irq_edge_detect.sv
// Purpose: Synchronise request lines and flag their rising edges
// Assumes: Request lines are asynchronous to mclk
// Notes:   Edge pulse is one cycle, three cycles after the pin rises
`timescale 1ns/1ps
module irq_edge_detect
   import gpe_pkg::*;
(
   input  wire logic                    mclk,
   input  wire logic                    sys_rst,
   input  wire logic [SOURCE_COUNT-1:0] irq_pin,
   output logic      [SOURCE_COUNT-1:0] irq_rise
);

   logic [SOURCE_COUNT-1:0] meta;
   logic [SOURCE_COUNT-1:0] synced;
   logic [SOURCE_COUNT-1:0] prev;
   logic [SOURCE_COUNT-1:0] next_rise;

   // Edge logic looks only at the second stage and its delayed copy prev, never at meta
   genvar i;
   generate
      for (i = 0; i < SOURCE_COUNT; i++) begin : g_line
         always_comb begin
            next_rise[i] = synced[i] & ~prev[i]; // [RQ14]
         end
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         meta     <= '0;
         synced   <= '0;
         prev     <= '0;
         irq_rise <= '0;
      end else begin
         meta     <= irq_pin;
         synced   <= meta;
         prev     <= synced;
         irq_rise <= next_rise;
      end
   end

endmodule

// ### rtl/acpi_gpe_event_logic.sv
// Purpose: General purpose event status/enable, SCI and SMI outputs, PM timer
// Assumes: Host I/O cycles arrive synchronous to mclk, one strobe per cycle
// Notes:   Read data appears the cycle after the read strobe
`timescale 1ns/1ps
module acpi_gpe_event_logic
   import gpe_pkg::*;
(
   input  wire logic                    mclk,
   input  wire logic                    sys_rst,
   input  wire logic [2:0]              io_addr,
   input  wire logic [7:0]              io_wdata,
   input  wire logic                    io_wr,
   input  wire logic                    io_rd,
   output logic      [7:0]              io_rdata,
   input  wire logic [SOURCE_COUNT-1:0] irq_pin,
   input  wire logic                    global_release_set,
   output logic                         global_release_request,
   output logic                         sci_out,
   output logic                         smi_event,
   output logic      [TIMER_WIDTH-1:0]  pm_timer_count
);

   ////////////////////////////////////////////////////////////////////////////
   logic [SOURCE_COUNT-1:0] irq_rise;
   logic [SOURCE_COUNT-1:0] event0_status;
   logic [SOURCE_COUNT-1:0] event0_enable;
   logic                    firmware_event_status;
   logic                    firmware_event_enable;
   logic                    pm_timer_run;
   logic [SOURCE_COUNT-1:0] next_event0_status;
   logic [SOURCE_COUNT-1:0] next_event0_enable;
   logic                    next_firmware_event_status;
   logic                    next_firmware_event_enable;
   logic                    next_pm_timer_run;
   logic                    next_global_release_request;
   logic                    next_sci_out;
   logic                    next_smi_event;
   logic [7:0]              next_io_rdata;
   logic [SOURCE_COUNT-1:0] status_clear;
   logic                    firmware_clear;

   irq_edge_detect u_edges (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .irq_pin  (irq_pin),
      .irq_rise (irq_rise)
   );

   function automatic logic wr_hit(input logic [2:0] ofs);
      return io_wr && (io_addr == ofs);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register state
   always_comb begin
      status_clear   = wr_hit(EVENT0_STATUS_OFS) ? io_wdata[SOURCE_COUNT-1:0] : '0; // [RQ3]
      firmware_clear = wr_hit(EVENT1_STATUS_OFS) && io_wdata[FIRMWARE_STATUS_BIT]; // [RQ10]
      // Set wins over clear so a request racing the write is kept
      next_event0_status = (event0_status & ~status_clear) | irq_rise; // [RQ1] [RQ4] [RQ14]
      next_event0_enable = wr_hit(EVENT0_ENABLE_OFS) ?
                           io_wdata[SOURCE_COUNT-1:0] : event0_enable; // [RQ6]
      next_firmware_event_enable = wr_hit(EVENT1_ENABLE_OFS) ?
                                   io_wdata[FIRMWARE_ENABLE_BIT] : firmware_event_enable;
      next_pm_timer_run = wr_hit(EVENT1_ENABLE_OFS) ?
                          io_wdata[TIMER_RUN_BIT] : pm_timer_run; // [RQ11]
      next_global_release_request = (global_release_request & ~firmware_clear)
                                    | global_release_set; // [RQ10]
      next_firmware_event_status = next_global_release_request
                                   | (firmware_event_status & ~firmware_clear); // [RQ8]
      next_smi_event = global_release_set & firmware_event_enable; // [RQ9]
      next_sci_out   = |(event0_status & event0_enable); // [RQ5]
   end

   // Read mux; reserved and wholly reserved registers return zero
   always_comb begin
      next_io_rdata = 8'h00;
      if (io_rd) begin
         unique case (io_addr)
            EVENT0_STATUS_OFS: next_io_rdata = {4'h0, event0_status}; // [RQ2]
            EVENT0_ENABLE_OFS: next_io_rdata = {4'h0, event0_enable}; // [RQ6]
            EVENT1_STATUS_OFS: next_io_rdata = {7'h00, firmware_event_status};
            EVENT1_ENABLE_OFS: next_io_rdata = {6'h00, pm_timer_run, firmware_event_enable};
            default:           next_io_rdata = 8'h00; // [RQ7]
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         event0_status          <= REG_RESET[SOURCE_COUNT-1:0]; // [RQ12]
         event0_enable          <= REG_RESET[SOURCE_COUNT-1:0];
         firmware_event_status  <= REG_RESET[0];
         firmware_event_enable  <= REG_RESET[0];
         pm_timer_run           <= REG_RESET[0];
         global_release_request <= 1'b0;
         sci_out                <= 1'b0;
         smi_event              <= 1'b0;
         io_rdata               <= 8'h00;
      end else begin
         event0_status          <= next_event0_status;
         event0_enable          <= next_event0_enable;
         firmware_event_status  <= next_firmware_event_status;
         firmware_event_enable  <= next_firmware_event_enable;
         pm_timer_run           <= next_pm_timer_run;
         global_release_request <= next_global_release_request;
         sci_out                <= next_sci_out;
         smi_event              <= next_smi_event;
         io_rdata               <= next_io_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // PM timer: fractional divider gives an average 3.579545 MHz tick
   logic [PHASE_WIDTH-1:0] phase;
   logic [PHASE_WIDTH-1:0] next_phase;
   logic [PHASE_WIDTH-1:0] phase_sum;
   logic                   timer_tick;
   logic                   next_timer_tick;
   logic [TIMER_WIDTH-1:0] next_pm_timer_count;

   always_comb begin
      phase_sum       = phase + PHASE_STEP;
      next_timer_tick = phase_sum >= PHASE_MODULO;
      next_phase      = next_timer_tick ? phase_sum - PHASE_MODULO : phase_sum;
      // Count only holds while halted, so it resumes where it stopped
      next_pm_timer_count = (timer_tick && pm_timer_run) ?
                            pm_timer_count + 1'b1 : pm_timer_count; // [RQ11] [RQ13]
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         phase          <= '0;
         timer_tick     <= 1'b0;
         pm_timer_count <= '0; // [RQ12]
      end else begin
         phase          <= next_phase;
         timer_tick     <= next_timer_tick;
         pm_timer_count <= next_pm_timer_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   status_set_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ1]
      (irq_rise != 0) |=> ((event0_status & $past(irq_rise)) == $past(irq_rise)))
      else $error("request did not set status");

   layout_read_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ2]
      (io_rd && io_addr == EVENT0_STATUS_OFS) |=> (io_rdata == {4'h0, $past(event0_status)}))
      else $error("status read layout wrong");

   status_clear_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ3]
      (wr_hit(EVENT0_STATUS_OFS) && irq_rise == 0)
      |=> ((event0_status & $past(io_wdata[3:0])) == 4'h0))
      else $error("status not cleared by write");

   status_hold_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ4]
      (status_clear == 0) |=> ((event0_status & $past(event0_status)) == $past(event0_status)))
      else $error("status lost without clear");

   sci_or_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ5]
      sci_out == |($past(event0_status) & $past(event0_enable)))
      else $error("sci does not follow status and enable");

   // Host leaves one idle cycle between a write and the following read
   enable_read_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ6]
      (io_wr && io_addr == EVENT0_ENABLE_OFS) ##1 !io_wr
      ##1 (io_rd && io_addr == EVENT0_ENABLE_OFS)
      |=> (io_rdata == {4'h0, $past(io_wdata[3:0], 3)}))
      else $error("enable readback wrong");

   reserved_zero_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ7]
      (io_rd && (io_addr == EVENT0_STATUS_HI_OFS || io_addr == EVENT0_ENABLE_HI_OFS
                 || io_addr == EVENT1_STATUS_HI_OFS)) |=> (io_rdata == 8'h00))
      else $error("reserved register not zero");

   firmware_set_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ8]
      global_release_set |=> (firmware_event_status && global_release_request))
      else $error("release did not set firmware status");

   smi_raise_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ9]
      (global_release_set && firmware_event_enable) |=> smi_event)
      else $error("smi not raised");

   firmware_clear_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ10]
      (firmware_clear && !global_release_set)
      |=> (!firmware_event_status && !global_release_request))
      else $error("firmware clear failed");

   timer_halt_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ11]
      !pm_timer_run |=> $stable(pm_timer_count))
      else $error("halted timer moved");

   reset_zero_a: assert property (@(posedge mclk) // [RQ12]
      sys_rst |=> (event0_status == 0 && event0_enable == 0 && !firmware_event_status
                   && !pm_timer_run && pm_timer_count == 0))
      else $error("register not zero after reset");

   timer_step_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ13]
      (timer_tick && pm_timer_run) |=> (pm_timer_count == $past(pm_timer_count) + 24'h000001))
      else $error("timer did not step");

   race_keep_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ14]
      (irq_rise[0] && status_clear[0]) |=> event0_status[0])
      else $error("racing request lost");

   sci_seen_c:   cover property (@(posedge mclk) disable iff (sys_rst) $rose(sci_out));
   smi_seen_c:   cover property (@(posedge mclk) disable iff (sys_rst) smi_event);
   clear_seen_c: cover property (@(posedge mclk) disable iff (sys_rst)
      event0_status[0] ##1 !event0_status[0]);

endmodule

// ### verification/gpe_host_model.sv
// Purpose: Host software model issuing system I/O cycles
// Assumes: One strobe per cycle, driven at the falling edge
// Notes:   Write data is inverted after use so stale values never match
`timescale 1ns/1ps
module gpe_host_model (
   input  wire logic       mclk,
   input  wire logic [7:0] io_rdata,
   output logic      [2:0] io_addr,
   output logic      [7:0] io_wdata,
   output logic            io_wr,
   output logic            io_rd
);
   initial begin
      io_addr = 3'h0;
      io_wdata = 8'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge mclk);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge mclk);
      io_wr = 1'b0;
      io_wdata = ~d;
   endtask

   // Data is taken the cycle after the strobe; it stands only then
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(negedge mclk);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge mclk);
      io_rd = 1'b0;
      d = io_rdata;
   endtask
endmodule

// ### verification/acpi_gpe_event_logic_tb_top.sv
// Purpose: Self-checking bench for the general purpose event block
// Assumes: Host model drives the I/O cycles
// Notes:   Timer bounds allow for 27 or 28 cycle tick spacing
`timescale 1ns/1ps
module acpi_gpe_event_logic_tb_top;
   import gpe_pkg::*;
   logic                    mclk;
   logic                    sys_rst;
   logic [SOURCE_COUNT-1:0] irq_pin;
   logic                    global_release_set;
   logic [2:0]              io_addr;
   logic [7:0]              io_wdata;
   logic                    io_wr;
   logic                    io_rd;
   logic [7:0]              io_rdata;
   logic                    global_release_request;
   logic                    sci_out;
   logic                    smi_event;
   logic [TIMER_WIDTH-1:0]  pm_timer_count;
   logic [TIMER_WIDTH-1:0]  c;
   int                      errors = 0;
   int                      total_checks = 0;
   int                      cycles = 0;

   acpi_gpe_event_logic dut (.mclk(mclk), .sys_rst(sys_rst), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
      .irq_pin(irq_pin), .global_release_set(global_release_set),
      .global_release_request(global_release_request), .sci_out(sci_out),
      .smi_event(smi_event), .pm_timer_count(pm_timer_count));
   gpe_host_model host (.mclk(mclk), .io_rdata(io_rdata), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic reg_is(input logic [2:0] a, input logic [7:0] e);
      logic [7:0] d;
      host.rd(a, d);
      check("rdata", {16'h0000, d}, {16'h0000, e});
   endtask

   // Pin held high a few cycles, then low long enough to resync
   task automatic pulse(input int i);
      @(negedge mclk);
      irq_pin[i] = 1'b1;
      repeat (3) @(negedge mclk);
      irq_pin[i] = 1'b0;
      repeat (6) @(negedge mclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      for (int a = 0; a < 8; a++) reg_is(3'(a), 8'h00);
      check("timer", pm_timer_count, 24'h000000);
   endtask

   task automatic t_enable();
      host.wr(3'h2, 8'hff);
      reg_is(3'h2, 8'h0f);
      for (int a = 1; a < 8; a += 2) begin
         host.wr(3'(a), 8'hff);
         reg_is(3'(a), 8'h00);
      end
   endtask

   task automatic t_irq();
      for (int i = 0; i < SOURCE_COUNT; i++) begin
         pulse(i);
         reg_is(3'h0, 8'h01 << i);
         check("sci", {23'h0, sci_out}, 24'h1);
         pulse(i);
         host.wr(3'h0, 8'h00);
         reg_is(3'h0, 8'h01 << i);
         host.wr(3'h0, 8'h01 << i);
         reg_is(3'h0, 8'h00);
         check("sci", {23'h0, sci_out}, 24'h0);
      end
      // Masked source: status set, output stays low
      host.wr(3'h2, 8'h0e);
      pulse(0);
      check("sci", {23'h0, sci_out}, 24'h0);
      host.wr(3'h2, 8'h01);
      reg_is(3'h0, 8'h01);
      check("sci", {23'h0, sci_out}, 24'h1);
      host.wr(3'h0, 8'h01);
   endtask

   // Request edge reaches status in the same cycle as a clearing write
   task automatic t_race();
      @(negedge mclk);
      irq_pin[0] = 1'b1;
      repeat (2) @(negedge mclk);
      host.wr(3'h0, 8'h01);
      reg_is(3'h0, 8'h01);
      irq_pin[0] = 1'b0;
      host.wr(3'h0, 8'h01);
      reg_is(3'h0, 8'h00);
   endtask

   task automatic t_release();
      for (int en = 0; en < 2; en++) begin
         host.wr(3'h6, 8'(en));
         reg_is(3'h6, 8'(en));
         @(negedge mclk);
         global_release_set = 1'b1;
         @(negedge mclk);
         global_release_set = 1'b0;
         check("smi", {23'h0, smi_event}, 24'(en));
         check("release", {23'h0, global_release_request}, 24'h1);
         reg_is(3'h4, 8'h01);
         host.wr(3'h4, 8'h00);
         reg_is(3'h4, 8'h01);
         host.wr(3'h4, 8'h01);
         reg_is(3'h4, 8'h00);
         check("release", {23'h0, global_release_request}, 24'h0);
      end
   endtask

   task automatic t_timer();
      host.wr(3'h6, 8'h02);
      repeat (280) @(negedge mclk);
      c = pm_timer_count;
      check("run", 24'(c >= 9 && c <= 11), 24'h1);
      host.wr(3'h6, 8'h00);
      c = pm_timer_count;
      repeat (100) @(negedge mclk);
      check("halt", pm_timer_count, c);
      host.wr(3'h6, 8'h02);
      reg_is(3'h6, 8'h02);
      repeat (60) @(negedge mclk);
      check("resume", 24'(pm_timer_count > c && pm_timer_count <= c + 3), 24'h1);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      if (errors == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Whole run needs under 2000 cycles
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors++;
         summarize();
      end
   end

   initial begin
      sys_rst = 1'b1;
      irq_pin = 4'h0;
      global_release_set = 1'b0;
      repeat (20) @(negedge mclk);
      sys_rst = 1'b0;
      t_reset();
      t_enable();
      t_irq();
      t_race();
      t_release();
      t_timer();
      summarize();
   end
endmodule
